// ---- opm_pkg.sv ----
package opm_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int NUM_PINS    = 12;   // out_pin0..out_pin7 plus out_pins_8_11
   localparam int NUM_SPECIAL = 8;    // Terminals that can carry a special signal
   localparam int DIV_W       = 6;    // Slow clock divider width (1/64)

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [11:0] DATA_RST = 12'hFFF;   // All data bits high
   localparam logic [11:0] HIZ_RST  = 12'h000;   // All terminals driven
   localparam logic [7:0]  SEL_RST  = 8'h00;     // All plain data outputs
   localparam logic [1:0]  FREQ_RST = 2'h0;      // Slow clock 1/64

   // ---------------------------------------------------------------
   // Function select bit positions (bit index equals terminal index)
   // ---------------------------------------------------------------
   localparam int SEL_INV_BUZZER = 0;   // inv_buzzer_select      -> out_pin0
   localparam int SEL_BUZZER     = 1;   // buzzer_select          -> out_pin1
   localparam int SEL_TIMER_CLK  = 2;   // timer_clock_out_enable -> out_pin2
   localparam int SEL_OSC_CLK    = 3;   // osc_clock_out_enable   -> out_pin3
   localparam int SEL_TX_MUTE    = 4;   // tx_mute_select         -> out_pin4
   localparam int SEL_RX_MUTE    = 5;   // rx_mute_select         -> out_pin5
   localparam int SEL_HOLD_LINE  = 6;   // hold_line_select       -> out_pin6
   localparam int SEL_HANDS_FREE = 7;   // hands_free_select      -> out_pin7

   // ---------------------------------------------------------------
   // Clock frequency select codes {clk_freq_sel_hi, clk_freq_sel_lo}
   // ---------------------------------------------------------------
   localparam logic [1:0] FREQ_FAST    = 2'h3;
   localparam logic [1:0] FREQ_SLOW    = 2'h2;
   localparam logic [1:0] FREQ_SLOW_8  = 2'h1;
   localparam logic [1:0] FREQ_SLOW_64 = 2'h0;
   localparam int DIV8_BIT  = 2;   // Counter bit toggling at slow/8
   localparam int DIV64_BIT = 5;   // Counter bit toggling at slow/64

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   // Software write port: one strobe and one data word per register
   typedef struct packed {
      logic        data_we;
      logic [11:0] data_wd;
      logic        hiz_we;
      logic [11:0] hiz_wd;
      logic        sel_we;
      logic [7:0]  sel_wd;
      logic        freq_we;
      logic [1:0]  freq_wd;   // {clk_freq_sel_hi, clk_freq_sel_lo}
   } opm_wr_t;

   // Special signals and their on/off controls from the source blocks
   typedef struct packed {
      logic inverted_buzzer_signal;
      logic buzzer_signal;
      logic buzzer_enable;
      logic timer_clock_output;
      logic transmit_mute_signal;
      logic tx_mute_ctrl;
      logic receive_mute_signal;
      logic rx_mute_ctrl;
      logic hold_line_signal;
      logic hold_line_ctrl;
      logic hands_free_signal;
      logic hands_free_ctrl;
   } opm_src_t;

   // Whole state of the port block
   typedef struct packed {
      logic [11:0]      data;       // Output data register
      logic [11:0]      hiz;        // pin_highz_ctrl register
      logic [7:0]       sel;        // Function select / output enable bits
      logic [1:0]       freq;       // Clock frequency select
      logic [2:0]       slow_sync;  // Slow oscillator synchroniser
      logic [2:0]       fast_sync;  // Fast oscillator synchroniser
      logic             slow_lvl;   // Filtered slow clock level
      logic             fast_lvl;   // Filtered fast clock level
      logic [DIV_W-1:0] div;        // Slow clock divider
      logic [11:0]      pin_out;    // Terminal level
      logic [11:0]      pin_oe;     // Terminal drive enable
   } opm_state_t;

endpackage

// ---- opm_port.sv ----
`timescale 1ns/100ps
// Functional notes
// - Hi-Z bit 1 releases the terminal
// - Hi-Z bit 0 drives data bit level
// - Reset: data ones, Hi-Z zeros, pins high
// - Special signals only on pins 0..7
// - Data 0 forces terminal low under special
// - Hi-Z 1 still releases special terminal
// - Glitch on special on/off is tolerated
// - Inverted buzzer to pin0, gated by enable
// - Buzzer to pin1, gated by buzzer enable
// - Timer clock on pin2 while enabled
// - Oscillator clock on pin3 while enabled
// - Frequency select picks pin3 clock source
// - Transmit mute to pin4, governed by control
// - Receive mute to pin5, governed by control
// - Hold line to pin6, governed by control
// - Hands-free to pin7, governed by control
// - Select 0 means plain output; resets 0

module opm_port (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire opm_pkg::opm_wr_t    wr,
   input  wire opm_pkg::opm_src_t   src,
   input  wire logic                slow_osc_clock,
   input  wire logic                fast_osc_clock,
   output logic [11:0]              pin_out,
   output logic [11:0]              pin_oe,
   output logic [11:0]              data_rd,
   output logic [11:0]              hiz_rd,
   output logic [7:0]               sel_rd,
   output logic [1:0]               freq_rd
);
   import opm_pkg::*;

   opm_state_t st;
   opm_state_t next_st;
   logic [7:0] special;
   logic       osc_clk;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Registers, synchronisers, divider and terminal logic
   always_comb begin
      next_st = st;
      special = 8'h00;
      osc_clk = 1'b0;
      // Software writes
      if (wr.data_we) begin
         next_st.data = wr.data_wd;
      end
      if (wr.hiz_we) begin
         next_st.hiz = wr.hiz_wd;
      end
      if (wr.sel_we) begin
         next_st.sel = wr.sel_wd;
      end
      if (wr.freq_we) begin
         next_st.freq = wr.freq_wd;
      end
      // Oscillator clocks come from another domain: three stages
      next_st.slow_sync = {st.slow_sync[1:0], slow_osc_clock};
      next_st.fast_sync = {st.fast_sync[1:0], fast_osc_clock};
      if (st.slow_sync[1] == st.slow_sync[2]) begin
         next_st.slow_lvl = st.slow_sync[2];
      end
      if (st.fast_sync[1] == st.fast_sync[2]) begin
         next_st.fast_lvl = st.fast_sync[2];
      end
      // Divide the slow clock on each accepted rising edge
      if (next_st.slow_lvl && !st.slow_lvl) begin
         next_st.div = st.div + DIV_W'(1);
      end
      // Clock source for out_pin3
      case (st.freq)
         FREQ_FAST:    osc_clk = st.fast_lvl;
         FREQ_SLOW:    osc_clk = st.slow_lvl;
         FREQ_SLOW_8:  osc_clk = st.div[DIV8_BIT];
         default:      osc_clk = st.div[DIV64_BIT];
      endcase
      // Enabled special signals
      special[SEL_INV_BUZZER] = src.inverted_buzzer_signal & src.buzzer_enable;
      special[SEL_BUZZER]     = src.buzzer_signal & src.buzzer_enable;
      special[SEL_TIMER_CLK]  = src.timer_clock_output;
      special[SEL_OSC_CLK]    = osc_clk;
      special[SEL_TX_MUTE]    = src.transmit_mute_signal & src.tx_mute_ctrl;
      special[SEL_RX_MUTE]    = src.receive_mute_signal & src.rx_mute_ctrl;
      special[SEL_HOLD_LINE]  = src.hold_line_signal & src.hold_line_ctrl;
      special[SEL_HANDS_FREE] = src.hands_free_signal & src.hands_free_ctrl;
      // Terminal levels; switching a source may glitch the pin
      for (int i = 0; i < NUM_SPECIAL; i++) begin
         if (st.sel[i]) begin
            next_st.pin_out[i] = special[i] & st.data[i];
         end else begin
            next_st.pin_out[i] = st.data[i];
         end
      end
      next_st.pin_out[11:8] = st.data[11:8];
      next_st.pin_oe        = ~st.hiz;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Reset leaves every terminal driven high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st.data      <= DATA_RST;
         st.hiz       <= HIZ_RST;
         st.sel       <= SEL_RST;
         st.freq      <= FREQ_RST;
         st.slow_sync <= 3'h0;
         st.fast_sync <= 3'h0;
         st.slow_lvl  <= 1'b0;
         st.fast_lvl  <= 1'b0;
         st.div       <= '0;
         st.pin_out   <= DATA_RST;
         st.pin_oe    <= ~HIZ_RST;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // All straight from the state register
   assign pin_out = st.pin_out;
   assign pin_oe  = st.pin_oe;
   assign data_rd = st.data;
   assign hiz_rd  = st.hiz;
   assign sel_rd  = st.sel;
   assign freq_rd = st.freq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   hiz_release_a: assert property (
      (st.pin_oe & $past(st.hiz)) == 12'h000)
      else $error("Terminal driven while its Hi-Z bit was set");

   drive_enable_a: assert property (
      $past(st.hiz[0]) == 1'b0 |-> st.pin_oe[0])
      else $error("Terminal 0 released with Hi-Z bit clear");

   plain_level_a: assert property (
      st.pin_out[11:8] == $past(st.data[11:8]))
      else $error("Upper terminals do not follow their data bits");

   low_force_a: assert property (
      (st.pin_out & ~$past(st.data)) == 12'h000)
      else $error("Terminal high while its data bit was 0");

   select_off_a: assert property (
      ((~$past(st.sel)) & (st.pin_out[7:0] ^ $past(st.data[7:0]))) == 8'h00)
      else $error("Unselected terminal differs from its data bit");

   buzzer_gate_a: assert property (
      st.sel[SEL_BUZZER] && !src.buzzer_enable |=> !st.pin_out[1])
      else $error("Buzzer terminal high with buzzer disabled");

   timer_route_a: assert property (
      st.sel[SEL_TIMER_CLK] && st.data[2] |=> st.pin_out[2] == $past(src.timer_clock_output))
      else $error("Timer clock not routed to terminal 2");

   osc_div64_a: assert property (
      st.sel[SEL_OSC_CLK] && st.data[3] && st.freq == FREQ_SLOW_64
      |=> st.pin_out[3] == $past(st.div[DIV64_BIT]))
      else $error("Terminal 3 not carrying slow clock divided by 64");

   hold_route_a: assert property (
      st.sel[SEL_HOLD_LINE] && st.data[6] && src.hold_line_ctrl
      |=> st.pin_out[6] == $past(src.hold_line_signal))
      else $error("Hold line signal not routed to terminal 6");

   data_write_a: assert property (
      wr.data_we && wr.hiz_we && wr.hiz_wd == 12'h000
      ##1 st.sel == 8'h00 |=> st.pin_out == $past(wr.data_wd, 2) && st.pin_oe == 12'hFFF)
      else $error("Driven terminals do not show written data");

   // ---------------------------------------------------------------
   // Register write checks
   // ---------------------------------------------------------------
   // A strobe loads the whole word; without one the word holds
   data_load_a: assert property (
      wr.data_we |=> st.data == $past(wr.data_wd))
      else $error("Data register missed a write");

   data_hold_a: assert property (
      !wr.data_we |=> st.data == $past(st.data))
      else $error("Data register changed without a write");

   hiz_load_a: assert property (
      wr.hiz_we |=> st.hiz == $past(wr.hiz_wd))
      else $error("Hi-Z register missed a write");

   hiz_hold_a: assert property (
      !wr.hiz_we |=> st.hiz == $past(st.hiz))
      else $error("Hi-Z register changed without a write");

   sel_load_a: assert property (
      wr.sel_we |=> st.sel == $past(wr.sel_wd))
      else $error("Select register missed a write");

   sel_hold_a: assert property (
      !wr.sel_we |=> st.sel == $past(st.sel))
      else $error("Select register changed without a write");

   freq_load_a: assert property (
      wr.freq_we |=> st.freq == $past(wr.freq_wd))
      else $error("Frequency select missed a write");

   freq_hold_a: assert property (
      !wr.freq_we |=> st.freq == $past(st.freq))
      else $error("Frequency select changed without a write");

   // ---------------------------------------------------------------
   // Terminal checks
   // ---------------------------------------------------------------
   // Drive enable is the Hi-Z word of one cycle before, inverted
   oe_follow_a: assert property (
      st.pin_oe == ~$past(st.hiz))
      else $error("Drive enable does not follow the Hi-Z word");

   // Hi-Z wins over a selected special signal
   special_release_a: assert property (
      (st.sel & st.hiz[7:0]) != 8'h00
      |=> (st.pin_oe[7:0] & $past(st.sel & st.hiz[7:0])) == 8'h00)
      else $error("Selected terminal driven while its Hi-Z bit was set");

   // A data bit of 0 wins over a selected special signal
   special_low_a: assert property (
      (st.sel & ~st.data[7:0]) != 8'h00
      |=> (st.pin_out[7:0] & $past(st.sel & ~st.data[7:0])) == 8'h00)
      else $error("Selected terminal high while its data bit was 0");

   // Clock terminals with their output off show the data bit
   timer_plain_a: assert property (
      !st.sel[SEL_TIMER_CLK] |=> st.pin_out[2] == $past(st.data[2]))
      else $error("Terminal 2 not plain with its clock output off");

   osc_plain_a: assert property (
      !st.sel[SEL_OSC_CLK] |=> st.pin_out[3] == $past(st.data[3]))
      else $error("Terminal 3 not plain with its clock output off");

   // Gated specials stay low while their gate is off
   inv_buzz_gate_a: assert property (
      st.sel[SEL_INV_BUZZER] && !src.buzzer_enable |=> !st.pin_out[0])
      else $error("Inverted buzzer terminal high with buzzer disabled");

   tx_gate_a: assert property (
      st.sel[SEL_TX_MUTE] && !src.tx_mute_ctrl |=> !st.pin_out[4])
      else $error("Transmit mute terminal high with its control off");

   rx_gate_a: assert property (
      st.sel[SEL_RX_MUTE] && !src.rx_mute_ctrl |=> !st.pin_out[5])
      else $error("Receive mute terminal high with its control off");

   hold_gate_a: assert property (
      st.sel[SEL_HOLD_LINE] && !src.hold_line_ctrl |=> !st.pin_out[6])
      else $error("Hold line terminal high with its control off");

   free_gate_a: assert property (
      st.sel[SEL_HANDS_FREE] && !src.hands_free_ctrl |=> !st.pin_out[7])
      else $error("Hands-free terminal high with its control off");

   // Enabled specials reach their terminal while the data bit is 1
   inv_buzz_route_a: assert property (
      st.sel[SEL_INV_BUZZER] && st.data[0] && src.buzzer_enable
      |=> st.pin_out[0] == $past(src.inverted_buzzer_signal))
      else $error("Inverted buzzer signal not routed to terminal 0");

   buzz_route_a: assert property (
      st.sel[SEL_BUZZER] && st.data[1] && src.buzzer_enable
      |=> st.pin_out[1] == $past(src.buzzer_signal))
      else $error("Buzzer signal not routed to terminal 1");

   tx_route_a: assert property (
      st.sel[SEL_TX_MUTE] && st.data[4] && src.tx_mute_ctrl
      |=> st.pin_out[4] == $past(src.transmit_mute_signal))
      else $error("Transmit mute signal not routed to terminal 4");

   rx_route_a: assert property (
      st.sel[SEL_RX_MUTE] && st.data[5] && src.rx_mute_ctrl
      |=> st.pin_out[5] == $past(src.receive_mute_signal))
      else $error("Receive mute signal not routed to terminal 5");

   free_route_a: assert property (
      st.sel[SEL_HANDS_FREE] && st.data[7] && src.hands_free_ctrl
      |=> st.pin_out[7] == $past(src.hands_free_signal))
      else $error("Hands-free signal not routed to terminal 7");

   // ---------------------------------------------------------------
   // Oscillator clock checks
   // ---------------------------------------------------------------
   // Each frequency code puts its own clock on terminal 3
   osc_fast_a: assert property (
      st.sel[SEL_OSC_CLK] && st.data[3] && st.freq == FREQ_FAST
      |=> st.pin_out[3] == $past(st.fast_lvl))
      else $error("Terminal 3 not carrying the fast clock");

   osc_slow_a: assert property (
      st.sel[SEL_OSC_CLK] && st.data[3] && st.freq == FREQ_SLOW
      |=> st.pin_out[3] == $past(st.slow_lvl))
      else $error("Terminal 3 not carrying the slow clock");

   osc_div8_a: assert property (
      st.sel[SEL_OSC_CLK] && st.data[3] && st.freq == FREQ_SLOW_8
      |=> st.pin_out[3] == $past(st.div[DIV8_BIT]))
      else $error("Terminal 3 not carrying slow clock divided by 8");

   // The divider steps once per accepted slow rising edge
   div_step_a: assert property (
      $rose(st.slow_lvl) |-> st.div == $past(st.div) + DIV_W'(1))
      else $error("Divider missed a slow clock edge");

   div_hold_a: assert property (
      !$rose(st.slow_lvl) |-> st.div == $past(st.div))
      else $error("Divider moved without a slow clock edge");

   // A level is accepted only when the last two stages agree
   slow_accept_a: assert property (
      st.slow_sync[1] == st.slow_sync[2] |=> st.slow_lvl == $past(st.slow_sync[2]))
      else $error("Slow clock level not accepted");

   slow_wait_a: assert property (
      st.slow_sync[1] != st.slow_sync[2] |=> st.slow_lvl == $past(st.slow_lvl))
      else $error("Slow clock level taken before the stages agree");

   fast_accept_a: assert property (
      st.fast_sync[1] == st.fast_sync[2] |=> st.fast_lvl == $past(st.fast_sync[2]))
      else $error("Fast clock level not accepted");

   fast_wait_a: assert property (
      st.fast_sync[1] != st.fast_sync[2] |=> st.fast_lvl == $past(st.fast_lvl))
      else $error("Fast clock level taken before the stages agree");

endmodule

// ---- opm_src_model.sv ----
`timescale 1ns/100ps
module opm_src_model
   import opm_pkg::*;
(
   input  wire logic   sys_clk,
   input  wire logic   fast_on,
   output opm_src_t    src,
   output logic        slow_osc_clock,
   output logic        fast_osc_clock
);
   // ---------------------------------------------
   // Source blocks
   // ---------------------------------------------
   // Signals and gates change just after each system edge
   initial src = '0;
   always @(posedge sys_clk) begin
      #1 src = opm_src_t'(12'($urandom()));
   end
   // Slow oscillator runs free, half period 400 ns
   initial slow_osc_clock = 1'b0;
   always #400 slow_osc_clock = ~slow_osc_clock;
   // Fast oscillator stays low until started
   initial fast_osc_clock = 1'b0;
   always #130 fast_osc_clock = fast_on ? ~fast_osc_clock : 1'b0;
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   import opm_pkg::*;
   logic          sys_clk, rst, fast_on, slow_osc_clock, fast_osc_clock, prev, in_band;
   opm_wr_t       wr;
   opm_src_t      src;
   logic [11:0]   pin_out, pin_oe, data_rd, hiz_rd, md, mh, eo, eh, em, pm, xm;
   logic [7:0]    sel_rd, ms;
   logic [1:0]    freq_rd, mf;
   int            num_errors, comparisons, rises, ex[4];
   // ---------------------------------------------
   // Clock, design and sources
   // ---------------------------------------------
   always #25 sys_clk = ~sys_clk;
   opm_port opm_port_i (.sys_clk(sys_clk), .rst(rst), .wr(wr), .src(src),
      .slow_osc_clock(slow_osc_clock), .fast_osc_clock(fast_osc_clock), .pin_out(pin_out),
      .pin_oe(pin_oe), .data_rd(data_rd), .hiz_rd(hiz_rd), .sel_rd(sel_rd), .freq_rd(freq_rd));
   opm_src_model opm_src_model_i (.sys_clk(sys_clk), .fast_on(fast_on), .src(src),
      .slow_osc_clock(slow_osc_clock), .fast_osc_clock(fast_osc_clock));
   // ---------------------------------------------
   // Expectation and comparison
   // ---------------------------------------------
   // Terminal levels from data, select and sources
   function automatic logic [11:0] exp_pins(logic [11:0] d, logic [7:0] s, opm_src_t r);
      logic [7:0] sp;
      sp = {r.hands_free_signal & r.hands_free_ctrl, r.hold_line_signal & r.hold_line_ctrl,
            r.receive_mute_signal & r.rx_mute_ctrl, r.transmit_mute_signal & r.tx_mute_ctrl,
            1'b0, r.timer_clock_output, r.buzzer_signal & r.buzzer_enable,
            r.inverted_buzzer_signal & r.buzzer_enable};
      return {d[11:8], (s & sp & d[7:0]) | (~s & d[7:0])};
   endfunction
   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Register model, outputs expected one edge later
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         md <= DATA_RST;
         mh <= HIZ_RST;
         ms <= SEL_RST;
         mf <= FREQ_RST;
         eo <= DATA_RST;
         eh <= ~HIZ_RST;
         em <= 12'h000;
      end else begin
         eo <= exp_pins(md, ms, src);
         eh <= ~mh;
         em <= {8'h00, ms[3], 3'h0};
         if (wr.data_we) md <= wr.data_wd;
         if (wr.hiz_we) mh <= wr.hiz_wd;
         if (wr.sel_we) ms <= wr.sel_wd;
         if (wr.freq_we) mf <= wr.freq_wd;
      end
   end
   // Pin levels with the oscillator terminal masked while selected
   assign pm = pin_out & ~em;
   assign xm = eo & ~em;
   // Every cycle, away from the clock edge
   always @(negedge sys_clk) begin
      check(pm & 12'h003, xm & 12'h003, "buzzer pins");
      check(pm & 12'h00C, xm & 12'h00C, "clock pins");
      check(pm & 12'h030, xm & 12'h030, "mute pins");
      check(pm & 12'h0C0, xm & 12'h0C0, "line pins");
      check(pm & 12'hF00, xm & 12'hF00, "plain pins");
      check(pin_oe, eh, "drive");
      check(data_rd, md, "data");
      check(hiz_rd, mh, "hiz");
      check({4'h0, sel_rd}, {4'h0, ms}, "select");
      check({10'h000, freq_rd}, {10'h000, mf}, "freq");
   end
   // ---------------------------------------------
   // Stimulus
   // ---------------------------------------------
   task automatic put(input logic [11:0] d, input logic [11:0] h, input logic [7:0] s,
                      input logic [1:0] f);
      @(posedge sys_clk);
      #1 wr = {1'b1, d, 1'b1, h, 1'b1, s, 1'b1, f};
      @(posedge sys_clk);
      #1 wr = '0;
   endtask
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      fast_on = 1'b0;
      wr = '0;
      num_errors = 0;
      comparisons = 0;
      ex = '{2, 16, 128, 393};
      void'($urandom(71910));
      repeat (12) @(posedge sys_clk);
      check(pin_out, DATA_RST, "reset level");
      check({4'h0, sel_rd}, {4'h0, SEL_RST}, "reset select");
      #1 rst = 1'b0;
      $display("test reset done");
      // Plain outputs: every select off, every terminal driven
      put(12'hA5A, 12'h000, 8'h00, 2'h0);
      repeat (4) @(posedge sys_clk);
      $display("test plain done");
      // Random writes, back to back, random sources
      repeat (600) begin
         @(posedge sys_clk);
         #1 wr = opm_wr_t'(38'({$urandom(), $urandom()}));
      end
      @(posedge sys_clk);
      #1 wr = '0;
      $display("test random done");
      // Reset again in mid-run, with the sources still moving
      @(posedge sys_clk);
      #1 rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      check(data_rd, DATA_RST, "mid reset data");
      check(pin_oe, ~HIZ_RST, "mid reset drive");
      #1 rst = 1'b0;
      $display("test mid reset done");
      // Specials held at data 1, driven; then data 0; then released
      put(12'hFFF, 12'h000, 8'hF7, 2'h0);
      repeat (100) @(posedge sys_clk);
      put(12'h000, 12'h000, 8'hF7, 2'h0);
      repeat (20) @(posedge sys_clk);
      put(12'hFFF, 12'hFFF, 8'hF7, 2'h0);
      repeat (20) @(posedge sys_clk);
      $display("test special done");
      // Oscillator clock rate for each frequency code
      for (int f = 0; f < 4; f++) begin
         fast_on = (f == 3);
         put(12'hFFF, 12'h000, 8'h08, 2'(f));
         rises = 0;
         prev = pin_out[3];
         repeat (2048) begin
            @(negedge sys_clk);
            if (pin_out[3] && !prev) rises++;
            prev = pin_out[3];
         end
         in_band = (rises >= ex[f] - 2) && (rises <= ex[f] + 2);
         check({11'h000, in_band}, 12'h001, "osc rate");
      end
      $display("test osc clock done");
      wrap_up();
   end
endmodule
